// ==== bench/hdlc_slot_partner.sv ====
// far-side model of the overhead bit slot: strobes slots and decodes the serial stream into frames.
// assumes the transmitter updates its bit at the edge that samples the slot strobe.
module hdlc_slot_partner
(
  // clock and controls from the bench
  input wire logic i_clk,
  input wire logic i_en,
  input wire logic i_inv,
  // serial line
  input wire logic i_tx_data,
  output logic o_slot = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic slot_seen = 1'b0;
  bit bits[$];
  logic [7:0] frame[$];
  int ones = 0;
  int n_frames = 0;
  int n_flags = 0;

  // one slot every other clock, so the line is never sampled twice per bit
  always @(posedge i_clk)
  begin
    o_slot <= i_en & ~o_slot;
    slot_seen <= o_slot;
  end

  // undo inversion, drop stuffed zeros, cut frames at flags
  always @(posedge i_clk)
    if (slot_seen)
      rx_bit(i_tx_data ^ i_inv);

  task automatic rx_bit(input bit b);
    logic [7:0] by;
    if (b)
    begin
      ones++;
      bits.push_back(1'b1);
      if (ones > 6)
        bits.delete(); // long ones run is idle fill, not data
    end
    else if (ones == 5)
      ones = 0;
    else if (ones == 6)
    begin
      ones = 0;
      n_flags++;
      repeat (7) if (bits.size() > 0) void'(bits.pop_back());
      if (bits.size() > 0 && bits.size() % 8 == 0)
      begin
        frame.delete();
        while (bits.size() > 0)
        begin
          for (int i = 0; i < 8; i++)
            by[i] = bits.pop_front();
          frame.push_back(by);
        end
        n_frames++;
      end
      bits.delete();
    end
    else
    begin
      ones = 0;
      bits.push_back(1'b0);
    end
  endtask
endmodule

// ==== bench/hdlc_transmit_packet_control_bench.sv ====
// testbench for the hdlc transmit controller: registers, framed output, interrupt, queue fill and flush.
// assumes the slot partner decodes the serial output; the design runs as port 1.
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module hdlc_transmit_packet_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import hdlc_tx_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, far_en = 1'b0, far_inv = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'h0;
  logic pready, pslverr, slot, tx_data, ram_pd, irq, err;
  int err_count = 0, num_checks = 0, nf, f0;
  logic [7:0] pkt[$] = '{8'hFF, 8'h3C, 8'h81, 8'hF8};
  logic [7:0] want[$];
  logic [15:0] cfg[6] = '{16'h0000, 16'h0008, 16'h0004, 16'h0002, 16'h0020, 16'h0022};

  // 25 MHz clock
  initial forever #20 mclk = ~mclk;

  hdlc_tx_ctrl #(.PORT_SEL(2'h1)) u_dut (.I_MCLK(mclk), .I_CE(1'b1), .I_RESET(rst), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_TX_SLOT(slot), .O_TX_DATA(tx_data),
    .O_RAM_PWR_DOWN(ram_pd), .O_IRQ(irq));
  hdlc_slot_partner u_far (.i_clk(mclk), .i_en(far_en), .i_inv(far_inv), .i_tx_data(tx_data), .o_slot(slot));

  // byte address of a register of port 1
  function automatic logic [15:0] ra(input logic [11:0] idx);
    return {2'h0, idx + 12'h200, 2'h0};
  endfunction

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge mclk);
    penable <= 1'b1;
    do
      @(posedge mclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] idx, input logic [15:0] d);
    apb(1'b1, ra(idx), {16'h0, d}, 4'hF);
  endtask
  task automatic rchk(input logic [11:0] idx, input logic [15:0] e);
    apb(1'b0, ra(idx), 32'h0, 4'h0);
    `CHK(rd, {16'h0, e})
  endtask
  task automatic push(input logic [7:0] b, input logic last);
    wr(IDX_DATA, {b, 7'h0, last});
  endtask
  task automatic send;
    foreach (pkt[i])
      push(pkt[i], 1'(i == pkt.size() - 1));
  endtask

  // expected frame body as it comes off the wire, with the fcs worked out over the sent bits
  task automatic frame_chk(input logic [15:0] c);
    logic [7:0] b;
    logic [15:0] crc;
    want.delete();
    crc = 16'hFFFF;
    foreach (pkt[i])
    begin
      b = pkt[i];
      if (c[CTRL_MSB])
        b = {<<{pkt[i]}};
      want.push_back(b);
      for (int k = 0; k < 8; k++)
        crc = (crc >> 1) ^ ((crc[0] ^ b[k]) ? 16'h8408 : 16'h0000);
    end
    if (!c[CTRL_OMIT])
    begin
      if (!c[CTRL_CORRUPT])
        crc = ~crc;
      want.push_back(crc[7:0]);
      want.push_back(crc[15:8]);
    end
    `CHK(u_far.n_frames, nf + 1)
    `CHK(u_far.frame.size(), want.size())
    foreach (want[i])
      `CHK(u_far.frame[i], want[i])
  endtask

  // verdict and end of run
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // main sequence
  initial
  begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    rchk(IDX_CTRL, 16'h0800);
    rchk(IDX_STAT, 16'h2003);
    rchk(IDX_LATCH, 16'h0000);
    rchk(IDX_IE, 16'h0000);
    rchk(IDX_DATA, 16'h0000);
    apb(1'b0, 16'h0280, 32'h0, 4'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    $display("test registers done");
    far_en <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      far_inv <= cfg[i][CTRL_INV];
      wr(IDX_CTRL, 16'h0840 | cfg[i]);
      repeat (100) @(posedge mclk);
      send();
      nf = u_far.n_frames;
      repeat (400) @(posedge mclk);
      `CHK(u_far.n_frames, nf)
      wr(IDX_CTRL, 16'h0800 | cfg[i]);
      repeat (400) @(posedge mclk);
      frame_chk(cfg[i]);
    end
    $display("test frames done");
    wr(IDX_CTRL, 16'h0810);
    repeat (50) @(posedge mclk);
    f0 = u_far.n_flags;
    repeat (200) @(posedge mclk);
    `CHK({u_far.n_flags == f0, u_far.ones > 64}, 2'b11)
    wr(IDX_CTRL, 16'h0800);
    repeat (50) @(posedge mclk);
    f0 = u_far.n_flags;
    repeat (200) @(posedge mclk);
    `CHK(1'(u_far.n_flags - f0 > 8), 1'b1)
    $display("test idle fill done");
    rchk(IDX_LATCH, 16'h000A);
    `CHK(irq, 1'b0)
    wr(IDX_IE, 16'h0008);
    repeat (3) @(posedge mclk);
    `CHK(irq, 1'b1)
    wr(IDX_LATCH, 16'h0008);
    repeat (3) @(posedge mclk);
    `CHK(irq, 1'b0)
    rchk(IDX_LATCH, 16'h0002);
    wr(IDX_LATCH, 16'h003B);
    $display("test interrupt done");
    wr(IDX_CTRL, 16'h1F40);
    apb(1'b1, ra(IDX_DATA), 32'h0000AA01, 4'h1);
    rchk(IDX_STAT, 16'h2003);
    for (int n = 1; n <= 257; n++)
    begin
      push(8'(n), 1'b0);
      case (n)
        7: rchk(IDX_STAT, 16'h1F01);
        8: rchk(IDX_STAT, 16'h1F00);
        255: rchk(IDX_STAT, 16'h0000);
        256: rchk(IDX_STAT, 16'h0004);
        default: ;
      endcase
    end
    rchk(IDX_LATCH, 16'h0020);
    $display("test fill done");
    wr(IDX_CTRL, 16'h1F41);
    repeat (2) @(posedge mclk);
    `CHK(ram_pd, 1'b1)
    push(8'h55, 1'b1);
    rchk(IDX_STAT, 16'h2003);
    wr(IDX_CTRL, 16'h1F40);
    push(8'h55, 1'b1);
    `CHK(ram_pd, 1'b0)
    rchk(IDX_STAT, 16'h2003);
    rchk(IDX_LATCH, 16'h0023);
    repeat (10) @(posedge mclk);
    push(8'h55, 1'b1);
    rchk(IDX_STAT, 16'h1F01);
    $display("test flush done");
    wr(IDX_LATCH, 16'h003B);
    nf = u_far.n_frames;
    wr(IDX_CTRL, 16'h0800);
    repeat (400) @(posedge mclk);
    `CHK(u_far.n_frames, nf + 1)
    push(8'hA5, 1'b0);
    repeat (400) @(posedge mclk);
    `CHK(u_far.frame.size(), 1)
    `CHK(u_far.frame[0], 8'hA5)
    rchk(IDX_LATCH, 16'h001A);
    $display("test underflow done");
    end_sim();
  end

  // watchdog against a hung handshake
  initial
  begin
    repeat (40000) @(posedge mclk);
    err_count++;
    end_sim();
  end
endmodule

// ==== rtl/hdlc_tx_ctrl.sv ====
// hdlc transmit packet controller for one port: apb register file, 256-byte
// transmit queue, and a bit-serial framer feeding the overhead bit slot.
// assumes the framer strobe I_TX_SLOT and the apb master share I_MCLK.
//
// Operation
// - the five registers sit at consecutive even indices A0..A8 with twice the port number as the upper digit.
// - storage is available only when free space is at least eight times the threshold field plus one.
// - with new-packet inhibit set the current packet ends and no new one starts.
// - the fcs is the inverted crc-16, or the plain crc-16 when corruption is asked and fcs is on.
// - between frames flag bytes are sent, or all ones when the fill select bit is set.
// - queue bytes go out lsb first, or msb first when the msb-first bit is set.
// - the output-invert bit inverts every outgoing bit.
// - fcs bytes are appended to every packet that ends on its last-byte mark, unless fcs-omit is set.
// - while flush is set the queue is empty, sending halts, the ram is off and data writes are dropped.
// - after flush clears, data writes are dropped until ram power-up ends.
// - the data register carries the byte in bits 15..8 and the last-byte mark in bit 0.
// - a byte is queued only on a write of the upper byte lane, and the data register reads zero.
// - storage-available status reads 1 when free space meets the threshold, else 0.
// - queue-full status reads 1 only when all 256 entries hold data.
//
// Added by the designer: the APB slave port.
module hdlc_tx_ctrl
#(
  parameter logic [1:0] PORT_SEL = 2'h0
)
(
  // clock, enable and reset
  input wire logic I_MCLK,
  input wire logic I_CE,
  input wire logic I_RESET,
  // apb slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [hdlc_tx_pkg::ADDR_W-1:0] I_PADDR,
  input wire logic [hdlc_tx_pkg::DATA_W-1:0] I_PWDATA,
  input wire logic [3:0] I_PSTRB,
  output logic [hdlc_tx_pkg::DATA_W-1:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // overhead bit slot
  input wire logic I_TX_SLOT,
  output logic O_TX_DATA,
  // housekeeping
  output logic O_RAM_PWR_DOWN,
  output logic O_IRQ
);
  import hdlc_tx_pkg::*;

  typedef enum logic [2:0] {IDLE_S, OPEN_S, DATA_S, FCS_LO_S, FCS_HI_S, CLOSE_S} tx_state_t;

  logic [15:0] ctrl_q, ctrl_d, ie_q, ie_d, lat_q, lat_d, w1c, evt, stat;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d, irq_q, irq_d;
  logic [8:0] mem [0:DEPTH-1];
  logic [PTR_W-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [CNT_W-1:0] count_q, count_d, free, thr_bytes;
  logic [3:0] pwr_cnt_q, pwr_cnt_d;
  logic ram_off_q, empty_prev_q, space_prev_q;
  tx_state_t state_q, state_d;
  logic [7:0] sreg_q, sreg_d, fcs_hi_q, fcs_hi_d, head_byte, head_ord;
  logic [2:0] bits_q, bits_d, ones_q, ones_d;
  logic [15:0] crc_q, crc_d, crc_new, fcs_word;
  logic last_q, last_d, txd_q, txd_d, head_end;
  logic [11:0] port_base, idx;
  logic addr_ok, hit_ctrl, hit_data, hit_stat, hit_lat, hit_ie, mapped, setup, access, wr;
  logic flush, discard, push_try, push, pop, ovf_evt, unf_evt, full, empty, space_ok;
  logic start_ok, out_bit, body, flush_fall;

  // one crc-16 step, reflected form, lsb of the transmitted stream first
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    logic [15:0] n;
    n = {1'b0, c[15:1]};
    if (c[0] ^ b)
      n = n ^ CRC_POLY_REV;
    return n;
  endfunction

  // address decode for this port's register block
  assign port_base = {1'b0, PORT_SEL, 9'h000};
  assign idx = I_PADDR[13:2];
  assign addr_ok = (I_PADDR[15:14] == 2'h0) && (I_PADDR[1:0] == 2'h0);
  assign hit_ctrl = addr_ok && (idx == port_base + IDX_CTRL);
  assign hit_data = addr_ok && (idx == port_base + IDX_DATA);
  assign hit_stat = addr_ok && (idx == port_base + IDX_STAT);
  assign hit_lat = addr_ok && (idx == port_base + IDX_LATCH);
  assign hit_ie = addr_ok && (idx == port_base + IDX_IE);
  assign mapped = hit_ctrl | hit_data | hit_stat | hit_lat | hit_ie;
  assign setup = I_PSEL & ~I_PENABLE & ~pready_q;
  assign access = I_PSEL & I_PENABLE & pready_q;
  assign wr = access & I_PWRITE;

  // queue occupancy and status word
  assign free = CNT_W'(DEPTH) - count_q;
  assign thr_bytes = {1'b0, ctrl_q[CTRL_THR_HI:CTRL_THR_LO], 3'h0} + 9'h001;
  assign space_ok = free >= thr_bytes;
  assign full = count_q == CNT_W'(DEPTH);
  assign empty = count_q == 9'h000;
  assign stat = {2'h0, free[8:3], 5'h00, full, empty, space_ok};

  // apb answer: ready one cycle after setup, so no wait state
  always_comb
  begin
    pready_d = setup;
    prdata_d = prdata_q;
    pslverr_d = pslverr_q;
    if (setup)
    begin
      pslverr_d = ~mapped;
      prdata_d = 32'h0000_0000; // data register and unmapped read zero
      if (hit_ctrl)
        prdata_d = {16'h0000, ctrl_q};
      if (hit_stat)
        prdata_d = {16'h0000, stat};
      if (hit_lat)
        prdata_d = {16'h0000, lat_q};
      if (hit_ie)
        prdata_d = {16'h0000, ie_q};
    end
  end

  // control, interrupt enable and write-one-to-clear decode
  always_comb
  begin
    ctrl_d = ctrl_q;
    ie_d = ie_q;
    w1c = 16'h0000;
    if (wr && hit_ctrl && I_PSTRB[0])
      ctrl_d[7:0] = I_PWDATA[7:0] & CTRL_WMASK[7:0];
    if (wr && hit_ctrl && I_PSTRB[1])
      ctrl_d[15:8] = I_PWDATA[15:8] & CTRL_WMASK[15:8];
    if (wr && hit_ie && I_PSTRB[0])
      ie_d[7:0] = I_PWDATA[7:0] & EVT_MASK[7:0];
    if (wr && hit_lat && I_PSTRB[0])
      w1c = I_PWDATA[15:0] & EVT_MASK;
  end

  // queue write side, flush and ram power sequencing
  assign flush = ctrl_q[CTRL_FLUSH];
  assign flush_fall = ram_off_q & ~flush;
  assign discard = ram_off_q | (pwr_cnt_q != 4'h0);
  assign push_try = wr & hit_data & I_PSTRB[1] & ~flush & ~discard;
  assign push = push_try & ~full;
  assign ovf_evt = push_try & full;

  always_comb
  begin
    pwr_cnt_d = pwr_cnt_q;
    if (flush)
      pwr_cnt_d = 4'h0;
    else if (flush_fall)
      pwr_cnt_d = POWERUP_LOAD;
    else if (pwr_cnt_q != 4'h0)
      pwr_cnt_d = pwr_cnt_q - 4'h1;
    count_d = CNT_W'(count_q + {8'h00, push} - {8'h00, pop});
    wr_ptr_d = PTR_W'(wr_ptr_q + {7'h00, push});
    rd_ptr_d = PTR_W'(rd_ptr_q + {7'h00, pop});
    if (flush)
    begin
      count_d = 9'h000;
      wr_ptr_d = 8'h00;
      rd_ptr_d = 8'h00;
    end
  end

  // queue head, reordered to suit an lsb-first shifter
  assign head_byte = mem[rd_ptr_q][8:1];
  assign head_end = mem[rd_ptr_q][0];
  generate
    for (genvar g = 0; g < 8; g++)
    begin : g_order
      assign head_ord[g] = ctrl_q[CTRL_MSB] ? head_byte[7-g] : head_byte[g];
    end
  endgenerate

  // crc over the current shifter bit and the fcs that would follow it
  assign crc_new = crc_step(crc_q, sreg_q[0]);
  assign fcs_word = ctrl_q[CTRL_CORRUPT] ? crc_new : ~crc_new;
  assign start_ok = ~empty & ~ctrl_q[CTRL_INHIBIT] & ~flush & ~discard;

  // bit engine: one bit per slot, next byte chosen as the last bit leaves
  always_comb
  begin
    state_d = state_q;
    sreg_d = sreg_q;
    bits_d = bits_q;
    ones_d = ones_q;
    crc_d = crc_q;
    fcs_hi_d = fcs_hi_q;
    last_d = last_q;
    txd_d = txd_q;
    pop = 1'b0;
    unf_evt = 1'b0;
    out_bit = 1'b0;
    body = (state_q == DATA_S) || (state_q == FCS_LO_S) || (state_q == FCS_HI_S);
    if (I_TX_SLOT)
    begin
      if (ones_q == STUFF_RUN)
        ones_d = 3'h0; // stuffed zero
      else
      begin
        out_bit = sreg_q[0];
        sreg_d = {1'b0, sreg_q[7:1]};
        ones_d = (body && out_bit) ? 3'(ones_q + 3'h1) : 3'h0;
        if (state_q == DATA_S)
          crc_d = crc_new;
        bits_d = 3'(bits_q + 3'h1);
        if (bits_q == 3'h7)
        begin
          unique case (state_q)
            IDLE_S, CLOSE_S:
            begin
              if (start_ok)
              begin
                sreg_d = FLAG_BYTE; // opening flag
                state_d = OPEN_S;
              end
              else
              begin
                sreg_d = ctrl_q[CTRL_FILL] ? ONES_BYTE : FLAG_BYTE;
                state_d = IDLE_S;
              end
            end
            OPEN_S:
            begin
              pop = 1'b1;
              sreg_d = head_ord;
              last_d = head_end;
              crc_d = CRC_INIT;
              state_d = DATA_S;
            end
            DATA_S:
            begin
              if (last_q && ctrl_q[CTRL_OMIT])
              begin
                sreg_d = FLAG_BYTE;
                state_d = CLOSE_S;
              end
              else if (last_q)
              begin
                sreg_d = fcs_word[7:0];
                fcs_hi_d = fcs_word[15:8];
                state_d = FCS_LO_S;
              end
              else if (empty)
              begin
                unf_evt = 1'b1;
                sreg_d = FLAG_BYTE;
                state_d = CLOSE_S;
              end
              else
              begin
                pop = 1'b1;
                sreg_d = head_ord;
                last_d = head_end;
              end
            end
            FCS_LO_S:
            begin
              sreg_d = fcs_hi_q;
              state_d = FCS_HI_S;
            end
            FCS_HI_S:
            begin
              sreg_d = FLAG_BYTE; // closing flag
              state_d = CLOSE_S;
            end
          endcase
        end
      end
      txd_d = out_bit ^ ctrl_q[CTRL_INV];
    end
    if (flush && (state_q != IDLE_S))
    begin
      pop = 1'b0; // a halted packet reads nothing and raises no event
      unf_evt = 1'b0;
      state_d = IDLE_S; // halt the packet in flight
      sreg_d = ctrl_q[CTRL_FILL] ? ONES_BYTE : FLAG_BYTE;
      bits_d = 3'h0;
      ones_d = 3'h0;
    end
  end

  // sticky events; a set in the clearing cycle wins
  always_comb
  begin
    evt = 16'h0000;
    evt[EVT_OVF] = ovf_evt;
    evt[EVT_UNF] = unf_evt;
    evt[EVT_PEND] = pop & head_end;
    evt[EVT_EMPTY] = (empty & ~empty_prev_q) | flush_fall;
    evt[EVT_SPACE] = (space_ok & ~space_prev_q) | flush_fall;
    lat_d = (lat_q & ~w1c) | evt;
    irq_d = |(lat_q & ie_q);
  end

  // queue storage, byte and end mark
  always_ff @(posedge I_MCLK)
  begin
    if (I_CE && push)
      mem[wr_ptr_q] <= {I_PWDATA[15:DATA_BYTE_LO], I_PWDATA[DATA_END]};
  end

  // state registers
  always_ff @(posedge I_MCLK)
  begin
    if (I_RESET)
    begin
      ctrl_q <= CTRL_RESET;
      ie_q <= IE_RESET;
      lat_q <= 16'h0000;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      irq_q <= 1'b0;
      wr_ptr_q <= 8'h00;
      rd_ptr_q <= 8'h00;
      count_q <= 9'h000;
      pwr_cnt_q <= 4'h0;
      ram_off_q <= 1'b0;
      empty_prev_q <= 1'b1;
      space_prev_q <= 1'b1;
      state_q <= IDLE_S;
      sreg_q <= FLAG_BYTE;
      bits_q <= 3'h0;
      ones_q <= 3'h0;
      crc_q <= CRC_INIT;
      fcs_hi_q <= 8'h00;
      last_q <= 1'b0;
      txd_q <= 1'b1;
    end
    else if (I_CE)
    begin
      ctrl_q <= ctrl_d;
      ie_q <= ie_d;
      lat_q <= lat_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      irq_q <= irq_d;
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q <= count_d;
      pwr_cnt_q <= pwr_cnt_d;
      ram_off_q <= flush;
      empty_prev_q <= empty;
      space_prev_q <= space_ok;
      state_q <= state_d;
      sreg_q <= sreg_d;
      bits_q <= bits_d;
      ones_q <= ones_d;
      crc_q <= crc_d;
      fcs_hi_q <= fcs_hi_d;
      last_q <= last_d;
      txd_q <= txd_d;
    end
  end

  // outputs straight from flops
  assign O_PRDATA = prdata_q;
  assign O_PREADY = pready_q;
  assign O_PSLVERR = pslverr_q;
  assign O_TX_DATA = txd_q;
  assign O_RAM_PWR_DOWN = ram_off_q;
  assign O_IRQ = irq_q;

  // checks on the behaviour above
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (I_RESET || !I_CE);

  flush_empties_a: assert property (flush |=> count_q == 9'h000)
    else $error("queue not emptied under flush");
  powerup_drop_a: assert property ($fell(flush) |-> discard [*8])
    else $error("writes accepted before ram power-up ended");
  space_read_a: assert property (setup && hit_stat |=>
    O_PRDATA[STAT_SPACE] == ((CNT_W'(DEPTH) - $past(count_q)) > {1'b0, $past(ctrl_q[12:8]), 3'h0}))
    else $error("space status disagrees with threshold");
  full_read_a: assert property (setup && hit_stat |=> O_PRDATA[STAT_FULL] == ($past(count_q) == 9'h100))
    else $error("full status wrong");
  inhibit_hold_a: assert property (ctrl_q[CTRL_INHIBIT] && state_q != OPEN_S |=> state_q != OPEN_S)
    else $error("packet started while inhibited");
  fcs_value_a: assert property (I_TX_SLOT && ones_q != STUFF_RUN && bits_q == 3'h7 && state_q == DATA_S
    && last_q && !ctrl_q[CTRL_OMIT] && !flush |=> state_q == FCS_LO_S
    && sreg_q == ($past(ctrl_q[CTRL_CORRUPT]) ? $past(crc_new[7:0]) : ~$past(crc_new[7:0])))
    else $error("wrong fcs byte loaded");
  fcs_omit_a: assert property (I_TX_SLOT && ones_q != STUFF_RUN && bits_q == 3'h7 && state_q == DATA_S
    && last_q && ctrl_q[CTRL_OMIT] && !flush |=> state_q == CLOSE_S && sreg_q == FLAG_BYTE)
    else $error("fcs sent while omitted");
  invert_out_a: assert property (I_TX_SLOT && ones_q != STUFF_RUN |=>
    O_TX_DATA == ($past(sreg_q[0]) ^ $past(ctrl_q[CTRL_INV])))
    else $error("output bit polarity wrong");
  stuff_zero_a: assert property (I_TX_SLOT && ones_q == STUFF_RUN && !flush
    |=> ones_q == 3'h0 && O_TX_DATA == $past(ctrl_q[CTRL_INV]) && $stable(sreg_q))
    else $error("no zero after five ones");
  bit_order_a: assert property (pop && !flush |=>
    sreg_q[0] == ($past(ctrl_q[CTRL_MSB]) ? $past(head_byte[7]) : $past(head_byte[0])))
    else $error("first bit of byte wrong");
  idle_fill_a: assert property (I_TX_SLOT && ones_q != STUFF_RUN && bits_q == 3'h7 && state_q == IDLE_S
    && !start_ok && !flush |=> sreg_q == ($past(ctrl_q[CTRL_FILL]) ? ONES_BYTE : FLAG_BYTE))
    else $error("wrong inter-frame fill");
endmodule

// ==== rtl/hdlc_tx_pkg.sv ====
// constants for the per-port hdlc transmit packet controller:
// register indices, field positions, reset values, framing bytes and timing.
// assumes a 25 MHz register clock and a single port instance per module.
package hdlc_tx_pkg;
  // bus and storage widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int DEPTH = 256;
  localparam int PTR_W = 8;
  localparam int CNT_W = 9;
  // register indices (byte address is four times the index)
  localparam logic [11:0] IDX_CTRL = 12'h0A0;
  localparam logic [11:0] IDX_DATA = 12'h0A2;
  localparam logic [11:0] IDX_STAT = 12'h0A4;
  localparam logic [11:0] IDX_LATCH = 12'h0A6;
  localparam logic [11:0] IDX_IE = 12'h0A8;
  // control register fields
  localparam int CTRL_THR_HI = 12;
  localparam int CTRL_THR_LO = 8;
  localparam int CTRL_INHIBIT = 6;
  localparam int CTRL_CORRUPT = 5;
  localparam int CTRL_FILL = 4;
  localparam int CTRL_MSB = 3;
  localparam int CTRL_INV = 2;
  localparam int CTRL_OMIT = 1;
  localparam int CTRL_FLUSH = 0;
  localparam logic [15:0] CTRL_RESET = 16'h0800;
  localparam logic [15:0] CTRL_WMASK = 16'h1F7F;
  // data register fields
  localparam int DATA_BYTE_LO = 8;
  localparam int DATA_END = 0;
  // status register fields
  localparam int STAT_FULL = 2;
  localparam int STAT_EMPTY = 1;
  localparam int STAT_SPACE = 0;
  // latched status and interrupt enable fields
  localparam int EVT_OVF = 5;
  localparam int EVT_UNF = 4;
  localparam int EVT_PEND = 3;
  localparam int EVT_EMPTY = 1;
  localparam int EVT_SPACE = 0;
  localparam logic [15:0] EVT_MASK = 16'h003B;
  localparam logic [15:0] IE_RESET = 16'h0000;
  // framing
  localparam logic [7:0] FLAG_BYTE = 8'h7E;
  localparam logic [7:0] ONES_BYTE = 8'hFF;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY_REV = 16'h8408;
  localparam logic [2:0] STUFF_RUN = 3'h5;
  // timing
  localparam int CLK_NS = 40;
  localparam int POWERUP_NS = 320;
  localparam int POWERUP_CYC = (POWERUP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] POWERUP_LOAD = 4'(POWERUP_CYC);
endpackage
